// ---- line_far_side.sv ----
`timescale 1ns/1ns
module line_far_side (
   // Bench controls
   input  wire logic       mclk_run,
   input  wire logic       e1_rate,
   input  wire logic       tclk_run,
   input  wire logic       rec_run,
   input  wire logic       sig_lost,
   input  wire logic [1:0] strap,
   // Device pins
   output logic            mclk_pin,
   output logic            tclk_pin,
   output logic            rx_rec_clk_pin,
   output logic            rx_sig_lost_pin,
   output logic [1:0]      mode_pin
);
   // ---------------------------------------------
   // Clock sources, standing still when stopped
   // ---------------------------------------------
   // Even half periods keep pin edges off the rising bench clock edges
   initial begin
      mclk_pin = 1'b0;
      forever begin
         #(e1_rate === 1'b0 ? 324 : 244);
         if (mclk_run) begin
            mclk_pin = ~mclk_pin;
         end
      end
   end
   initial begin
      tclk_pin = 1'b0;
      forever begin
         #(e1_rate === 1'b0 ? 326 : 246);
         if (tclk_run) begin
            tclk_pin = ~tclk_pin;
         end
      end
   end
   initial begin
      rx_rec_clk_pin = 1'b0;
      forever begin
         #(e1_rate === 1'b0 ? 322 : 242);
         if (rec_run) begin
            rx_rec_clk_pin = ~rx_rec_clk_pin;
         end
      end
   end
   // ---------------------------------------------
   // Detector and straps
   // ---------------------------------------------
   assign rx_sig_lost_pin = sig_lost;
   assign mode_pin        = strap;
endmodule : line_far_side

// ---- master_clock_and_mode_select.sv ----
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
// Behaviour
// - Reference is 2.048 MHz for E1, 1.544 MHz for T1/J1; software picks.
// - Reference ticks time clock recovery, jitter attenuator and control interface.
// - During loss of signal the receive clock comes from the reference.
// - Selected reference clocks all-ones, zeros, PRBS/QRSS and loopback codes.
// - Automatic all-ones and AIS are always timed from the reference.
// - Hardware mode times all-ones and PRBS/QRSS from the reference.
// - Lost reference puts both transmit line outputs into high impedance.
// - Loss-of-signal output goes high when receive signal is lost.
// - Loss-of-signal output returns low by itself when signal returns.
// - Two select pin levels choose which control interface is in charge.
// - Select 00 hardware, 01 serial, 10 and 11 multiplexed parallel styles.
module master_clock_and_mode_select #(
   parameter int unsigned MON_CNT_W = 9
) (
   // Clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave
   input  wire logic [7:0]             paddr,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Asynchronous timing and status pins
   input  wire logic                   mclk_pin,
   input  wire logic                   tclk_pin,
   input  wire logic                   rx_rec_clk_pin,
   input  wire logic                   rx_sig_lost_pin,
   // Control straps and hardware-mode pins
   input  wire logic [1:0]             mode_pin,
   input  wire logic                   hw_tx_all_ones_pin,
   input  wire logic                   hw_prbs_pin,
   // Transmit line data from the encoder
   input  wire logic                   tx_pos,
   input  wire logic                   tx_neg,
   // Timing outputs
   output logic                        ref_tick,
   output logic                        rx_clk_o,
   output logic                        tx_ref_tick,
   output mclk_sel_pkg::tx_pat_e       tx_pattern,
   // Line driver outputs
   output logic                        tx_line_tip_o,
   output logic                        tx_line_tip_oe,
   output logic                        tx_line_ring_o,
   output logic                        tx_line_ring_oe,
   // Status outputs
   output logic                        los,
   output logic                        auto_tx_all_ones,
   output mclk_sel_pkg::ctrl_if_e      ctrl_if
);
   import mclk_sel_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0]        tclk_s;
      logic              tclk_prev;
      logic [1:0]        rec_s;
      logic [1:0]        los_s;
      logic [1:0]        hw_ones_s;
      logic [1:0]        hw_prbs_s;
      logic [1:0]        mode_s0;
      logic [1:0]        mode_s1;
      logic [1:0]        cap_cnt;
      ctrl_if_e          ctrl_if;
      logic [CTRL_W-1:0] ctrl;
      logic [31:0]       prdata;
      logic              los;
      logic              rx_clk;
      logic              tx_tick;
      tx_pat_e           pat;
      logic              tip;
      logic              tip_oe;
      logic              ring;
      logic              ring_oe;
      logic              ref_tick;
      logic              auto_ones;
   } top_s;

   localparam top_s TOP_RST = '{ctrl: CTRL_RST, ctrl_if: IF_HW, pat: PAT_DATA, default: '0};

   top_s    q;
   top_s    d;
   logic    mon_tick;
   logic    mon_lvl;
   logic    mon_lost;
   logic    mon_rate_err;
   logic    tclk_rise;
   logic    hw_mode;
   logic    auto_ones;
   logic    sys_force;
   logic    hw_force;
   logic    use_mclk;
   tx_pat_e pat_sel;
   logic    wr_ctrl;
   logic    unmapped;

   // ---------------------------------------------------------------
   // Reference clock monitor
   // ---------------------------------------------------------------
   mclk_monitor #(
      .CNT_W     (MON_CNT_W)
   ) u_mon (
      .pclk      (pclk),
      .presetn   (presetn),
      .mclk_pin  (mclk_pin),
      .e1_mode   (q.ctrl[CTRL_E1]),
      .mclk_tick (mon_tick),
      .mclk_lvl  (mon_lvl),
      .mclk_lost (mon_lost),
      .rate_err  (mon_rate_err)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;

      // Pin synchronisers
      d.tclk_s    = {q.tclk_s[0], tclk_pin};
      d.tclk_prev = q.tclk_s[1];
      d.rec_s     = {q.rec_s[0], rx_rec_clk_pin};
      d.los_s     = {q.los_s[0], rx_sig_lost_pin};
      d.hw_ones_s = {q.hw_ones_s[0], hw_tx_all_ones_pin};
      d.hw_prbs_s = {q.hw_prbs_s[0], hw_prbs_pin};
      d.mode_s0   = mode_pin;
      d.mode_s1   = q.mode_s0;
      tclk_rise   = q.tclk_s[1] & ~q.tclk_prev;

      // Strap capture shortly after reset release, then frozen
      if (q.cap_cnt != STRAP_DONE) begin
         d.ctrl_if = ctrl_if_e'(q.mode_s1);
         d.cap_cnt = q.cap_cnt + 1'b1;
      end

      // Loss of signal follows the detector both ways
      d.los = q.los_s[1];

      // Receive clock source
      d.rx_clk = q.los ? mon_lvl : q.rec_s[1];

      // Control-interface timing reference
      d.ref_tick = mon_tick;

      // Transmit pattern and its timing reference
      hw_mode   = (q.ctrl_if == IF_HW);
      auto_ones = !hw_mode && q.ctrl[CTRL_AUTO_ONES] && q.los;
      sys_force = auto_ones || (!hw_mode && q.ctrl[CTRL_AIS]);
      hw_force  = hw_mode && (q.hw_ones_s[1] || q.hw_prbs_s[1]);
      if (hw_mode) begin
         if (q.hw_ones_s[1]) begin
            pat_sel = PAT_ONES;
         end else if (q.hw_prbs_s[1]) begin
            pat_sel = PAT_PRBS;
         end else begin
            pat_sel = PAT_DATA;
         end
      end else if (sys_force) begin
         pat_sel = PAT_ONES;
      end else begin
         case (q.ctrl[CTRL_PAT_LSB +: CTRL_PAT_W])
            PAT_ONES:  pat_sel = PAT_ONES;
            PAT_ZEROS: pat_sel = PAT_ZEROS;
            PAT_PRBS:  pat_sel = PAT_PRBS;
            PAT_LB_UP: pat_sel = PAT_LB_UP;
            PAT_LB_DN: pat_sel = PAT_LB_DN;
            default:   pat_sel = PAT_DATA;
         endcase
      end
      use_mclk = hw_force || sys_force
                 || (!hw_mode && pat_sel != PAT_DATA && q.ctrl[CTRL_TXREF]);
      d.tx_tick   = use_mclk ? mon_tick : tclk_rise;
      d.pat       = pat_sel;
      d.auto_ones = auto_ones;

      // Line drivers released only while the reference runs
      d.tip     = tx_pos;
      d.ring    = tx_neg;
      d.tip_oe  = !mon_lost;
      d.ring_oe = !mon_lost;

      // APB: write in access phase, read data prepared in setup
      wr_ctrl  = psel && penable && pwrite && (paddr == ADDR_CTRL);
      unmapped = (paddr != ADDR_CTRL) && (paddr != ADDR_STATUS);
      if (wr_ctrl) begin
         d.ctrl = pwdata[CTRL_W-1:0];
      end
      if (psel && !penable) begin
         d.prdata = 32'h0000_0000;
         if (paddr == ADDR_CTRL) begin
            d.prdata[CTRL_W-1:0] = q.ctrl;
         end else if (paddr == ADDR_STATUS) begin
            d.prdata[ST_LOS]             = q.los;
            d.prdata[ST_MLOST]           = mon_lost;
            d.prdata[ST_RATE]            = mon_rate_err;
            d.prdata[ST_IF_LSB +: 2]     = q.ctrl_if;
            d.prdata[ST_HIZ]             = !q.tip_oe;
            d.prdata[ST_AUTO]            = q.auto_ones;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= TOP_RST;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata           = q.prdata;
   assign pready           = 1'b1;
   assign pslverr          = psel && penable && unmapped;
   assign ref_tick         = q.ref_tick;
   assign rx_clk_o         = q.rx_clk;
   assign tx_ref_tick      = q.tx_tick;
   assign tx_pattern       = q.pat;
   assign tx_line_tip_o    = q.tip;
   assign tx_line_tip_oe   = q.tip_oe;
   assign tx_line_ring_o   = q.ring;
   assign tx_line_ring_oe  = q.ring_oe;
   assign los              = q.los;
   assign auto_tx_all_ones = q.auto_ones;
   assign ctrl_if          = q.ctrl_if;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_sig_lost;
      rx_sig_lost_pin [*4];
   endsequence

   sequence s_sig_back;
      !rx_sig_lost_pin [*4];
   endsequence

   sequence s_wr_ctrl;
      psel && penable && pwrite && (paddr == ADDR_CTRL);
   endsequence

   a_ctrl_write: assert property (s_wr_ctrl |=>
      q.ctrl[CTRL_E1] == $past(pwdata[CTRL_E1]))
      else $error("rate select not written");

   a_ref_timing: assert property (mon_tick |=> ref_tick)
      else $error("reference tick not forwarded");

   a_rx_clk_src: assert property (los |=> rx_clk_o == $past(mon_lvl))
      else $error("receive clock not from reference during loss");

   a_pat_mclk: assert property ((!hw_mode && !sys_force && pat_sel != PAT_DATA
      && q.ctrl[CTRL_TXREF]) |=> tx_ref_tick == $past(mon_tick))
      else $error("pattern not timed from reference");

   a_auto_mclk: assert property (sys_force |=>
      tx_ref_tick == $past(mon_tick) && tx_pattern == PAT_ONES)
      else $error("automatic all ones not timed from reference");

   a_hw_mclk: assert property (hw_force |=> tx_ref_tick == $past(mon_tick))
      else $error("hardware pattern not timed from reference");

   a_drv_hiz: assert property (mon_lost |=> !tx_line_tip_oe && !tx_line_ring_oe)
      else $error("line driven without reference");

   a_rx_clk_rec: assert property (!los |=>
      rx_clk_o == $past(q.rec_s[1]))
      else $error("receive clock not from recovered timing");

   a_drv_on: assert property (!mon_lost |=>
      tx_line_tip_oe && tx_line_ring_oe)
      else $error("line drivers idle with reference running");

   a_auto_level: assert property ((!hw_mode && q.ctrl[CTRL_AUTO_ONES] && los) |=>
      auto_tx_all_ones && tx_pattern == PAT_ONES)
      else $error("automatic all ones not raised");

   a_los_raise: assert property (s_sig_lost |-> los)
      else $error("loss of signal not reported");

   a_los_clear: assert property (s_sig_back |-> !los)
      else $error("loss of signal not released");

   a_strap_hold: assert property ((q.cap_cnt == STRAP_DONE) |=> $stable(ctrl_if))
      else $error("control interface changed after capture");

   a_strap_decode: assert property ((q.cap_cnt != STRAP_DONE) |=>
      ctrl_if == $past(q.mode_s1))
      else $error("select straps decoded wrongly");

endmodule : master_clock_and_mode_select

// ---- mclk_monitor.sv ----
`timescale 1ns/1ns
module mclk_monitor #(
   parameter int unsigned CNT_W = 9
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Reference pin and rate select
   input  wire logic mclk_pin,
   input  wire logic e1_mode,
   // Derived timing
   output logic      mclk_tick,
   output logic      mclk_lvl,
   output logic      mclk_lost,
   output logic      rate_err
);
   import mclk_sel_pkg::*;

   typedef struct packed {
      logic [1:0]       sync;
      logic             prev;
      logic [CNT_W-1:0] idle;
      logic [CNT_W-1:0] period;
      logic             seen;
      logic             tick;
      logic             lost;
      logic             rate_err;
   } mon_s;

   localparam logic [CNT_W-1:0] LOSS_LIM = CNT_W'(MCLK_LOSS_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_MAX  = '1;
   localparam mon_s             MON_RST  = '{lost: 1'b1, default: '0};

   mon_s q;
   mon_s d;
   logic edge_any;
   logic rise;

   function automatic logic in_window(input logic [CNT_W-1:0] meas,
                                      input int unsigned nom);
      return (32'(meas) + PERIOD_TOL_CYC >= nom) && (32'(meas) <= nom + PERIOD_TOL_CYC);
   endfunction : in_window

   // ---------------------------------------------------------------
   // Edge, loss and rate tracking
   // ---------------------------------------------------------------
   always_comb begin
      d        = q;
      d.sync   = {q.sync[0], mclk_pin};
      d.prev   = q.sync[1];
      edge_any = q.sync[1] ^ q.prev;
      rise     = q.sync[1] & ~q.prev;
      d.tick   = rise;
      if (edge_any) begin
         d.idle = '0;
         d.lost = 1'b0;
      end else if (q.idle >= LOSS_LIM) begin
         d.lost = 1'b1;
         d.seen = 1'b0;
      end else begin
         d.idle = q.idle + 1'b1;
      end
      // Period held as cycles minus one since the previous rise
      if (rise) begin
         if (q.seen) begin
            d.rate_err = e1_mode ? !in_window(q.period, E1_PERIOD_CYC - 1)
                                 : !in_window(q.period, T1_PERIOD_CYC - 1);
         end
         d.period = '0;
         d.seen   = 1'b1;
      end else if (q.period != CNT_MAX) begin
         d.period = q.period + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= MON_RST;
      end else begin
         q <= d;
      end
   end

   assign mclk_tick = q.tick;
   assign mclk_lvl  = q.sync[1];
   assign mclk_lost = q.lost;
   assign rate_err  = q.rate_err;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_loss_clears: assert property (@(posedge pclk) disable iff (!presetn)
      edge_any |=> !mclk_lost)
      else $error("reference edge did not clear loss");

   a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
      mclk_tick |=> !mclk_tick)
      else $error("reference tick lasted two cycles");

endmodule : mclk_monitor

// ---- mclk_sel_pkg.sv ----
package mclk_sel_pkg;

   // ---------------------------------------------------------------
   // Rates and timing
   // ---------------------------------------------------------------
   localparam int unsigned PCLK_KHZ       = 100000;
   localparam int unsigned MCLK_E1_KHZ    = 2048;
   localparam int unsigned MCLK_T1_KHZ    = 1544;
   localparam int unsigned E1_PERIOD_CYC  = PCLK_KHZ / MCLK_E1_KHZ;
   localparam int unsigned T1_PERIOD_CYC  = PCLK_KHZ / MCLK_T1_KHZ;
   localparam int unsigned PERIOD_TOL_CYC = 4;
   localparam int unsigned MCLK_LOSS_CYC  = 256;
   localparam logic [1:0]  STRAP_DONE     = 2'h3;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W      = 8;
   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_STATUS = 8'h04;

   localparam int unsigned CTRL_E1        = 0;
   localparam int unsigned CTRL_TXREF     = 1;
   localparam int unsigned CTRL_PAT_LSB   = 2;
   localparam int unsigned CTRL_PAT_W     = 3;
   localparam int unsigned CTRL_AUTO_ONES = 5;
   localparam int unsigned CTRL_AIS       = 6;
   localparam int unsigned CTRL_W         = 7;
   localparam logic [6:0]  CTRL_RST       = 7'h00;

   localparam int unsigned ST_LOS    = 0;
   localparam int unsigned ST_MLOST  = 1;
   localparam int unsigned ST_RATE   = 2;
   localparam int unsigned ST_IF_LSB = 3;
   localparam int unsigned ST_HIZ    = 5;
   localparam int unsigned ST_AUTO   = 6;

   // ---------------------------------------------------------------
   // Modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      IF_HW     = 2'b00,
      IF_SERIAL = 2'b01,
      IF_MUX_A  = 2'b10,
      IF_MUX_B  = 2'b11
   } ctrl_if_e;

   typedef enum logic [2:0] {
      PAT_DATA  = 3'b000,
      PAT_ONES  = 3'b001,
      PAT_ZEROS = 3'b010,
      PAT_PRBS  = 3'b011,
      PAT_LB_UP = 3'b100,
      PAT_LB_DN = 3'b101
   } tx_pat_e;

endpackage : mclk_sel_pkg

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
   import mclk_sel_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, rx_prev;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        mclk_run, e1_rate, tclk_run, rec_run, sig_lost;
   logic [1:0]  strap, mode_pin;
   logic        mclk_pin, tclk_pin, rec_pin, lost_pin, hw_ones, hw_prbs, tx_pos, tx_neg;
   logic        ref_tick, rx_clk_o, tx_ref_tick, tip_o, tip_oe, ring_o, ring_oe, los, auto_ones;
   tx_pat_e     tx_pattern;
   ctrl_if_e    ctrl_if;
   int          mismatches, checks, n_ref, n_txr, n_rxr;

   master_clock_and_mode_select DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mclk_pin(mclk_pin), .tclk_pin(tclk_pin),
      .rx_rec_clk_pin(rec_pin), .rx_sig_lost_pin(lost_pin), .mode_pin(mode_pin),
      .hw_tx_all_ones_pin(hw_ones), .hw_prbs_pin(hw_prbs), .tx_pos(tx_pos), .tx_neg(tx_neg),
      .ref_tick(ref_tick), .rx_clk_o(rx_clk_o), .tx_ref_tick(tx_ref_tick),
      .tx_pattern(tx_pattern), .tx_line_tip_o(tip_o), .tx_line_tip_oe(tip_oe),
      .tx_line_ring_o(ring_o), .tx_line_ring_oe(ring_oe), .los(los),
      .auto_tx_all_ones(auto_ones), .ctrl_if(ctrl_if));
   line_far_side far (.mclk_run(mclk_run), .e1_rate(e1_rate), .tclk_run(tclk_run),
      .rec_run(rec_run), .sig_lost(sig_lost), .strap(strap), .mclk_pin(mclk_pin),
      .tclk_pin(tclk_pin), .rx_rec_clk_pin(rec_pin), .rx_sig_lost_pin(lost_pin),
      .mode_pin(mode_pin));

   // ---------------------------------------------
   // Clock and edge counters
   // ---------------------------------------------
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (ref_tick === 1'b1) n_ref++;
      if (tx_ref_tick === 1'b1) n_txr++;
      if (rx_clk_o === 1'b1 && rx_prev === 1'b0) n_rxr++;
      rx_prev = rx_clk_o;
   end

   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task test_done;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   task tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : tick
   task apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task do_reset(input logic [1:0] s);
      @(posedge pclk);
      strap   <= s;
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      tick(6);
   endtask : do_reset
   task measure(input string nm, input int sel, input int n, input int lo, input int hi);
      int a[3];
      a = '{n_ref, n_txr, n_rxr};
      tick(n);
      a = '{n_ref - a[0], n_txr - a[1], n_rxr - a[2]};
      check(nm, 32'(a[sel] >= lo && a[sel] <= hi), 32'h0000_0001);
   endtask : measure

   // ---------------------------------------------
   // Watchdog
   // ---------------------------------------------
   initial begin
      #800_000;
      mismatches++;
      test_done();
   end

   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {mclk_run, e1_rate, tclk_run, rec_run, sig_lost} = 5'b1_1000;
      {strap, hw_ones, hw_prbs, tx_pos, tx_neg} = '0;
      {mismatches, checks, n_ref, n_txr, n_rxr, rx_prev} = '0;
      for (int m = 0; m < 4; m++) begin
         do_reset(m[1:0]);
         check("ctrl_if", ctrl_if, m);
         apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
         check("status if", rd[ST_IF_LSB +: 2], m);
         apb(ADDR_CTRL, 1'b0, 32'h0000_0000);
         check("ctrl reset", rd, 32'h0000_0000);
         strap <= ~m[1:0];
         tick(10);
         check("ctrl_if held", ctrl_if, m);
         $display("strap test %0d done", m);
      end
      do_reset(2'b01);
      apb(ADDR_CTRL, 1'b1, 32'hFFFF_FFFF);
      apb(ADDR_CTRL, 1'b0, 32'h0000_0000);
      check("ctrl width", rd, 32'h0000_007F);
      apb(ADDR_STATUS, 1'b1, 32'hFFFF_FFFF);
      check("status write err", err, 1'b0);
      apb(8'h08, 1'b0, 32'h0000_0000);
      check("unmapped err", err, 1'b1);
      check("unmapped data", rd, 32'h0000_0000);
      apb(ADDR_CTRL, 1'b1, 32'h0000_0000);
      tick(300);
      apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
      check("rate wrong", rd[ST_RATE], 1'b1);
      check("status if kept", rd[ST_IF_LSB +: 2], 2'b01);
      apb(ADDR_CTRL, 1'b1, 32'h0000_0001);
      tick(300);
      apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
      check("rate right", rd[ST_RATE], 1'b0);
      measure("ref ticks", 0, 1000, 18, 22);
      apb(ADDR_CTRL, 1'b1, 32'h0000_0000);
      e1_rate <= 1'b0;
      tick(300);
      apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
      check("rate t1", rd[ST_RATE], 1'b0);
      e1_rate <= 1'b1;
      $display("register and rate tests done");
      measure("rx clk no los", 2, 1000, 0, 0);
      rec_run <= 1'b1;
      measure("rx clk recovered", 2, 1000, 18, 22);
      @(posedge pclk);
      rec_run  <= 1'b0;
      sig_lost <= 1'b1;
      tick(2);
      check("los early", los, 1'b0);
      tick(1);
      check("los set", los, 1'b1);
      measure("rx clk from ref", 2, 1000, 18, 22);
      apb(ADDR_CTRL, 1'b1, 32'h0000_0021);
      tick(3);
      check("auto ones", auto_ones, 1'b1);
      check("auto pattern", tx_pattern, PAT_ONES);
      measure("auto ticks", 1, 1000, 18, 22);
      apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
      check("status los", rd[ST_LOS], 1'b1);
      check("status auto", rd[ST_AUTO], 1'b1);
      sig_lost <= 1'b0;
      tick(5);
      check("los clear", los, 1'b0);
      check("auto off", auto_ones, 1'b0);
      apb(ADDR_CTRL, 1'b1, 32'h0000_0041);
      tick(3);
      check("ais pattern", tx_pattern, PAT_ONES);
      measure("ais ticks", 1, 1000, 18, 22);
      $display("loss of signal tests done");
      for (int p = 1; p < 6; p++) begin
         apb(ADDR_CTRL, 1'b1, 32'(3 | (p << 2)));
         tick(3);
         check("pattern", tx_pattern, p);
         measure("pattern ticks", 1, 500, 9, 11);
      end
      apb(ADDR_CTRL, 1'b1, 32'h0000_0009);
      tick(3);
      measure("pattern tclk ref", 1, 500, 0, 0);
      apb(ADDR_CTRL, 1'b1, 32'h0000_0001);
      tick(3);
      measure("data no tclk", 1, 500, 0, 0);
      tclk_run <= 1'b1;
      measure("data tclk", 1, 1000, 18, 22);
      $display("pattern tests done");
      @(posedge pclk);
      tx_pos <= 1'b1;
      tick(4);
      check("tip data", tip_o, 1'b1);
      check("ring data", ring_o, 1'b0);
      check("tip on", tip_oe, 1'b1);
      mclk_run <= 1'b0;
      tick(300);
      check("tip hiz", tip_oe, 1'b0);
      check("ring hiz", ring_oe, 1'b0);
      apb(ADDR_STATUS, 1'b0, 32'h0000_0000);
      check("status lost", rd[ST_MLOST], 1'b1);
      check("status hiz", rd[ST_HIZ], 1'b1);
      mclk_run <= 1'b1;
      tick(30);
      check("ring back", ring_oe, 1'b1);
      @(posedge pclk);
      tx_pos <= 1'b0;
      tx_neg <= 1'b1;
      tick(2);
      check("tip data low", tip_o, 1'b0);
      check("ring data high", ring_o, 1'b1);
      $display("reference loss test done");
      tclk_run <= 1'b0;
      do_reset(2'b00);
      @(posedge pclk);
      hw_ones <= 1'b1;
      hw_prbs <= 1'b1;
      tick(5);
      check("hw ones", tx_pattern, PAT_ONES);
      measure("hw ones ticks", 1, 1000, 18, 22);
      @(posedge pclk);
      hw_ones <= 1'b0;
      tick(5);
      check("hw prbs", tx_pattern, PAT_PRBS);
      measure("hw prbs ticks", 1, 1000, 18, 22);
      $display("hardware mode test done");
      test_done();
   end
endmodule : tb
